// ===== rtl/bsp_boot_strap.sv
// boot strap capture, pad reset defaults and axi4-lite register block
//
// Functional notes
// [RULE1] Boot mode comes from the two strap pads as sampled when reset is released.
// [RULE2] After reset completes the strap pads behave as ordinary function pads.
// [RULE3] A second strap reading 1 selects flash boot whatever the first strap reads.
// [RULE4] First strap 1 with second strap 0 selects joint download over serial port or usb.
// [RULE5] A reset code 0 pad comes up with input off and no pulls, high impedance.
// [RULE6] A reset code 1 pad comes up with input on and no pulls, high impedance.
// [RULE7] A reset code 2 pad comes up with input on and the weak pull-down on.
// [RULE8] A reset code 3 pad comes up with input on and the weak pull-up on.
// [RULE9] A reset code 4 pad comes up with output on and the weak pull-up on.
// [RULE10] The debug clock pad pull-up at reset is on when the fuse is 0 and off when it is 1; the code keeps it on in reset for either fuse value.
// [RULE11] With usb enabled the usb data pads take their pull-up from the usb pull-up control.
// [RULE12] With usb disabled the usb pads are ordinary pads, pulls off by default, configurable.
// [RULE13] Each pad takes its mux default function unless the routing matrix overrides it.
// [RULE14] Every pad has a fixed reset code from a table, applied whenever reset is asserted.
// [RULE15] The board holds the second strap high and floats the first so flash boot is default.
`default_nettype none

module bsp_boot_strap import bsp_pkg::*; #(
  parameter int NPAD = PAD_COUNT
) (
  // clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        resetn,
  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic [2:0]                  s_axi_awprot,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0]           s_axi_araddr,
  input  wire logic [2:0]                  s_axi_arprot,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  // pad side inputs
  input  wire logic [NPAD-1:0]             padIn,
  input  wire logic [NPAD-1:0][FUNC_N-1:0] padFuncOut,
  input  wire logic [NPAD-1:0]             padMatrixOut,
  input  wire logic                        fuseDebugPadDisable,
  // pad controls
  output logic [NPAD-1:0]                  padInputBufferEnable,
  output logic [NPAD-1:0]                  padOutputEnable,
  output logic [NPAD-1:0]                  padWeakPullupCtl,
  output logic [NPAD-1:0]                  padWeakPulldownCtl,
  output logic [NPAD-1:0]                  padUsbPadPullupCtl,
  output logic [NPAD-1:0]                  padOut,
  output logic [USB_VAL_W-1:0]             usbPullupValue,
  // boot mode
  output bsp_boot_mode_t                   bootMode,
  output logic                             bootModeValid
);

  localparam int IDXW = $clog2(NPAD);

  // the reset table and the 32-bit input readback fix the pad count
  if (NPAD != PAD_COUNT || NPAD > 32) begin : g_bad_npad
    $error("bsp_boot_strap: NPAD must equal the pad table size");
  end

  typedef struct packed {
    logic                       awRdy;
    logic                       wRdy;
    logic                       bValid;
    logic [1:0]                 bResp;
    logic                       arRdy;
    logic                       rValid;
    logic [1:0]                 rResp;
    logic [31:0]                rData;
    logic                       awHave;
    logic [ADDR_W-1:0]          awAddr;
    logic                       wHave;
    logic [31:0]                wData;
    logic [3:0]                 wStrb;
    logic                       captured;
    logic                       strapA;
    logic                       strapB;
    logic                       fuse;
    bsp_boot_mode_t             mode;
    logic [USB_CTRL_W-1:0]      usbCtrl;
    logic [NPAD-1:0][CFG_W-1:0] cfg;
    logic [NPAD-1:0]            ie;
    logic [NPAD-1:0]            oe;
    logic [NPAD-1:0]            weak_pullup_ctl;
    logic [NPAD-1:0]            weak_pulldown_ctl;
    logic [NPAD-1:0]            usbPu;
    logic [NPAD-1:0]            dout;
  } bsp_state_t;

  bsp_state_t s_r;
  bsp_state_t s_nxt;
  logic       rstMeta_r;
  logic       rstN_r;

  bsp_pad_if #(.NPAD(NPAD)) pif ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic pad_hit(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_PAD_CFG_BASE;
    return (a >= ADDR_PAD_CFG_BASE) && (a[1:0] == 2'h0) &&
           (off[ADDR_W-1:2] < (ADDR_W-2)'(NPAD));
  endfunction

  function automatic logic [IDXW-1:0] pad_idx(logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_PAD_CFG_BASE;
    return off[IDXW+1:2];
  endfunction

  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return m;
  endfunction

  // constant image loaded whenever reset is asserted
  function automatic bsp_state_t reset_state();
    bsp_state_t r;
    r       = '0;
    r.awRdy = 1'b1;
    r.wRdy  = 1'b1;
    r.arRdy = 1'b1;
    r.mode  = BOOT_NONE;
    r.usbCtrl = USB_CTRL_RST;
    for (int i = 0; i < NPAD; i++) begin
      r.cfg[i] = pad_reset_cfg(PAD_RST_CODE[i]);  // RULE5 RULE6 RULE7 RULE8 RULE9 RULE14
      r.ie[i]  = r.cfg[i][CFG_IE];
      r.oe[i]  = r.cfg[i][CFG_OE];
      r.weak_pullup_ctl[i] = r.cfg[i][CFG_WPU];
      r.weak_pulldown_ctl[i] = r.cfg[i][CFG_WPD];
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // pad decode
  // ----------------------------------------------------------------
  assign pif.cfg       = s_r.cfg;
  assign pif.funcOut   = padFuncOut;
  assign pif.matrixOut = padMatrixOut;
  assign pif.usbEn     = s_r.usbCtrl[USB_EN_BIT];
  assign pif.dpPullup  = s_r.usbCtrl[USB_DP_BIT];
  assign pif.dmPullup  = s_r.usbCtrl[USB_DM_BIT];
  assign pif.strapHold = !s_r.captured;

  bsp_pad_decode #(.NPAD(NPAD)) u_decode (
    .pads (pif.dec)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wordOld;
    logic [31:0] wordNew;
    wordOld = 32'h0;
    wordNew = 32'h0;
    s_nxt   = s_r;

    // straps are taken in the first cycle after reset release, once
    if (!s_r.captured) begin
      s_nxt.captured = 1'b1;
      s_nxt.strapA   = padIn[STRAP_A_IDX];  // RULE1
      s_nxt.strapB   = padIn[STRAP_B_IDX];  // RULE1
      s_nxt.fuse     = fuseDebugPadDisable;
      if (padIn[STRAP_B_IDX]) begin
        s_nxt.mode = BOOT_FLASH;  // RULE3
      end else if (padIn[STRAP_A_IDX]) begin
        s_nxt.mode = BOOT_JOINT_DL;  // RULE4
      end else begin
        s_nxt.mode = BOOT_UNDEFINED;
      end
      if (fuseDebugPadDisable) begin
        s_nxt.cfg[DEBUG_CLK_IDX][CFG_WPU] = 1'b0;  // RULE10
      end
    end

    // write channels are taken independently, in either order
    if (s_axi_awvalid && s_r.awRdy) begin
      s_nxt.awHave = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
      s_nxt.awRdy  = 1'b0;
    end
    if (s_axi_wvalid && s_r.wRdy) begin
      s_nxt.wHave = 1'b1;
      s_nxt.wData = s_axi_wdata;
      s_nxt.wStrb = s_axi_wstrb;
      s_nxt.wRdy  = 1'b0;
    end
    if (s_r.awHave && s_r.wHave && !s_r.bValid) begin
      s_nxt.awHave = 1'b0;
      s_nxt.wHave  = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp  = RESP_OKAY;
      if (s_r.awAddr == ADDR_USB_CTRL) begin
        wordOld = 32'(s_r.usbCtrl);
        wordNew = merge(wordOld, s_r.wData, s_r.wStrb);
        s_nxt.usbCtrl = wordNew[USB_CTRL_W-1:0];  // RULE11 RULE12
      end else if (pad_hit(s_r.awAddr)) begin
        wordOld = 32'(s_r.cfg[pad_idx(s_r.awAddr)]);
        wordNew = merge(wordOld, s_r.wData, s_r.wStrb);
        s_nxt.cfg[pad_idx(s_r.awAddr)] = wordNew[CFG_W-1:0];  // RULE12 RULE13
      end else if (s_r.awAddr != ADDR_BOOT_STATUS && s_r.awAddr != ADDR_PAD_IN) begin
        s_nxt.bResp = RESP_SLVERR;
      end
    end
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'b0;
      s_nxt.awRdy  = 1'b1;
      s_nxt.wRdy   = 1'b1;
    end

    // read: one outstanding, answered one cycle after the address is taken
    if (s_axi_arvalid && s_r.arRdy) begin
      s_nxt.arRdy  = 1'b0;
      s_nxt.rValid = 1'b1;
      s_nxt.rResp  = RESP_OKAY;
      s_nxt.rData  = 32'h0;
      if (s_axi_araddr == ADDR_BOOT_STATUS) begin
        s_nxt.rData = {26'h0, s_r.fuse, s_r.captured, s_r.strapB, s_r.strapA, s_r.mode};
      end else if (s_axi_araddr == ADDR_USB_CTRL) begin
        s_nxt.rData = 32'(s_r.usbCtrl);
      end else if (s_axi_araddr == ADDR_PAD_IN) begin
        s_nxt.rData = 32'(padIn & s_r.ie);
      end else if (pad_hit(s_axi_araddr)) begin
        s_nxt.rData = 32'(s_r.cfg[pad_idx(s_axi_araddr)]);
      end else begin
        s_nxt.rResp = RESP_SLVERR;
      end
    end
    if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'b0;
      s_nxt.arRdy  = 1'b1;
    end

    // pad controls registered so every pin level leaves a flip-flop
    s_nxt.ie    = pif.ie;
    s_nxt.oe    = pif.oe;  // RULE2
    s_nxt.weak_pullup_ctl   = pif.weak_pullup_ctl;
    s_nxt.weak_pulldown_ctl   = pif.weak_pulldown_ctl;
    s_nxt.usbPu = pif.usbPu;
    s_nxt.dout  = pif.dout;
  end

  always_ff @(posedge sys_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      s_r <= reset_state();  // RULE14
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready        = s_r.awRdy;
  assign s_axi_wready         = s_r.wRdy;
  assign s_axi_bvalid         = s_r.bValid;
  assign s_axi_bresp          = s_r.bResp;
  assign s_axi_arready        = s_r.arRdy;
  assign s_axi_rvalid         = s_r.rValid;
  assign s_axi_rresp          = s_r.rResp;
  assign s_axi_rdata          = s_r.rData;
  assign padInputBufferEnable = s_r.ie;
  assign padOutputEnable      = s_r.oe;
  assign padWeakPullupCtl     = s_r.weak_pullup_ctl;
  assign padWeakPulldownCtl   = s_r.weak_pulldown_ctl;
  assign padUsbPadPullupCtl   = s_r.usbPu;
  assign padOut               = s_r.dout;
  assign usbPullupValue       = s_r.usbCtrl[USB_VAL_LSB +: USB_VAL_W];
  assign bootMode             = s_r.mode;
  assign bootModeValid        = s_r.captured;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // sampled rstN_r skips the release edge, where s_r still holds its reset image
  a_strap_sample: assert property (  // RULE1
    @(posedge sys_clk) disable iff (!rstN_r)
    rstN_r && !s_r.captured |=> s_r.captured && s_r.strapA == $past(padIn[STRAP_A_IDX])
                      && s_r.strapB == $past(padIn[STRAP_B_IDX]) && $rose(s_r.captured)
  ) else $error("straps not captured in the first cycle after release");

  a_strap_released: assert property (  // RULE2
    @(posedge sys_clk) disable iff (!rstN_r)
    s_r.captured ##1 s_r.captured |-> s_r.oe[STRAP_A_IDX] == $past(s_r.cfg[STRAP_A_IDX][CFG_OE])
  ) else $error("strap pad output enable not following its configuration");

  a_flash_boot: assert property (  // RULE3
    @(posedge sys_clk) disable iff (!rstN_r)
    s_r.captured && s_r.strapB |-> s_r.mode == BOOT_FLASH && bootModeValid
  ) else $error("second strap high did not select flash boot");

  a_joint_download: assert property (  // RULE4
    @(posedge sys_clk) disable iff (!rstN_r)
    s_r.captured && s_r.strapA && !s_r.strapB |-> s_r.mode == BOOT_JOINT_DL
  ) else $error("joint download not selected");

  for (genvar i = 0; i < NPAD; i++) begin : g_chk
    if (i != DEBUG_CLK_IDX) begin : g_tab
      a_reset_table: assert property (  // RULE14
        @(posedge sys_clk) disable iff (!rstN_r)
        rstN_r && !s_r.captured |=> s_r.cfg[i] == pad_reset_cfg(PAD_RST_CODE[i])
                          ##1 (s_r.ie[i] == pad_reset_cfg(PAD_RST_CODE[i])[CFG_IE]
                               || $past(s_r.cfg[i]) != pad_reset_cfg(PAD_RST_CODE[i]))
      ) else $error("pad configuration differs from its reset code");
    end
  end

  a_pull_codes: assert property (  // RULE5 RULE6 RULE8 RULE9
    @(posedge sys_clk) disable iff (!rstN_r)
    !s_r.captured |-> s_r.weak_pullup_ctl[14] && s_r.ie[14] && !s_r.ie[0] && !s_r.weak_pulldown_ctl[0]
                      && s_r.oe[15] && s_r.weak_pullup_ctl[15] && s_r.ie[2] && !s_r.weak_pullup_ctl[2]
  ) else $error("pad reset levels differ from codes");

  a_debug_fuse: assert property (  // RULE10
    @(posedge sys_clk) disable iff (!rstN_r)
    $rose(s_r.captured) |-> s_r.cfg[DEBUG_CLK_IDX][CFG_WPU] == !s_r.fuse
                            && s_r.cfg[DEBUG_CLK_IDX][CFG_IE]
  ) else $error("debug clock pad pull-up ignores the fuse");

  a_usb_pullup: assert property (  // RULE11
    @(posedge sys_clk) disable iff (!rstN_r)
    rstN_r && s_r.usbCtrl[USB_EN_BIT] |=> !s_r.weak_pullup_ctl[USB_PLUS_IDX]
      && s_r.usbPu[USB_PLUS_IDX] == $past(s_r.usbCtrl[USB_DP_BIT])
  ) else $error("usb plus pad pull-up not from the usb control");

  a_usb_off: assert property (  // RULE12
    @(posedge sys_clk) disable iff (!rstN_r)
    !s_r.usbCtrl[USB_EN_BIT] |=> !s_r.usbPu[USB_MINUS_IDX]
      && s_r.weak_pulldown_ctl[USB_MINUS_IDX] == $past(s_r.cfg[USB_MINUS_IDX][CFG_WPD])
  ) else $error("usb minus pad not an ordinary pad with usb off");

  a_matrix_route: assert property (  // RULE13
    @(posedge sys_clk) disable iff (!rstN_r)
    s_r.cfg[0][CFG_MTX] |=> s_r.dout[0] == $past(padMatrixOut[0])
  ) else $error("routing matrix did not override the pad function");

endmodule

`default_nettype wire

// ===== rtl/bsp_pkg.sv
// shared constants, pad reset table and types of the boot strap and pad default block
`default_nettype none

package bsp_pkg;

  // ----------------------------------------------------------------
  // pad population
  // ----------------------------------------------------------------
  localparam int PAD_COUNT     = 19;
  localparam int DEBUG_CLK_IDX = 4;
  localparam int STRAP_A_IDX   = 6;
  localparam int STRAP_B_IDX   = 7;
  localparam int USB_MINUS_IDX = 17;
  localparam int USB_PLUS_IDX  = 18;
  localparam int FUNC_N        = 3;

  // ----------------------------------------------------------------
  // per-pad reset codes
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_IN_OFF   = 3'h0;
  localparam logic [2:0] RST_IN_HIZ   = 3'h1;
  localparam logic [2:0] RST_IN_PD    = 3'h2;
  localparam logic [2:0] RST_IN_PU    = 3'h3;
  localparam logic [2:0] RST_OUT_PU   = 3'h4;
  localparam logic [2:0] RST_DBG_FUSE = 3'h5;
  localparam logic [2:0] RST_USB_PU   = 3'h6;

  localparam logic [2:0] PAD_RST_CODE [PAD_COUNT] = '{
    RST_IN_OFF, RST_IN_OFF, RST_IN_HIZ, RST_IN_HIZ, RST_DBG_FUSE,
    RST_IN_HIZ, RST_IN_HIZ, RST_IN_PU,  RST_IN_OFF, RST_IN_OFF,
    RST_IN_OFF, RST_IN_OFF, RST_IN_OFF, RST_IN_OFF, RST_IN_PU,
    RST_OUT_PU, RST_IN_HIZ, RST_IN_HIZ, RST_USB_PU};

  // ----------------------------------------------------------------
  // pad configuration word layout
  // ----------------------------------------------------------------
  localparam int CFG_W     = 7;
  localparam int CFG_IE    = 0;
  localparam int CFG_OE    = 1;
  localparam int CFG_WPU   = 2;
  localparam int CFG_WPD   = 3;
  localparam int CFG_MTX   = 4;
  localparam int CFG_FUNC  = 5;
  localparam int CFG_FUNCW = 2;

  // ----------------------------------------------------------------
  // usb control word layout
  // ----------------------------------------------------------------
  localparam int              USB_CTRL_W   = 6;
  localparam int              USB_EN_BIT   = 0;
  localparam int              USB_DP_BIT   = 1;
  localparam int              USB_DM_BIT   = 2;
  localparam int              USB_VAL_LSB  = 3;
  localparam int              USB_VAL_W    = 3;
  localparam logic [5:0]      USB_CTRL_RST = 6'h03;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         ADDR_W            = 8;
  localparam logic [7:0] ADDR_BOOT_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_USB_CTRL     = 8'h04;
  localparam logic [7:0] ADDR_PAD_IN       = 8'h08;
  localparam logic [7:0] ADDR_PAD_CFG_BASE = 8'h40;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  typedef enum logic [1:0] {
    BOOT_NONE,
    BOOT_FLASH,
    BOOT_JOINT_DL,
    BOOT_UNDEFINED
  } bsp_boot_mode_t;

  // reset code to configuration word; code 5 assumes the fuse reads 0
  function automatic logic [CFG_W-1:0] pad_reset_cfg(logic [2:0] code);
    logic [CFG_W-1:0] c;
    c = '0;
    case (code)
      RST_IN_HIZ, RST_USB_PU: c[CFG_IE] = 1'b1;
      RST_IN_PD: begin
        c[CFG_IE]  = 1'b1;
        c[CFG_WPD] = 1'b1;
      end
      RST_IN_PU, RST_DBG_FUSE: begin
        c[CFG_IE]  = 1'b1;
        c[CFG_WPU] = 1'b1;
      end
      RST_OUT_PU: begin
        c[CFG_OE]  = 1'b1;
        c[CFG_WPU] = 1'b1;
      end
      default: c = '0;
    endcase
    return c;
  endfunction

endpackage

`default_nettype wire

// ===== rtl/bsp_pad_if.sv
// carrier between the register block and the pad decoder
`default_nettype none

interface bsp_pad_if import bsp_pkg::*; #(
  parameter int NPAD = PAD_COUNT
) ();
  logic [NPAD-1:0][CFG_W-1:0]  cfg;
  logic [NPAD-1:0][FUNC_N-1:0] funcOut;
  logic [NPAD-1:0]             matrixOut;
  logic                        usbEn;
  logic                        dpPullup;
  logic                        dmPullup;
  logic                        strapHold;
  logic [NPAD-1:0]             ie;
  logic [NPAD-1:0]             oe;
  logic [NPAD-1:0]             weak_pullup_ctl;
  logic [NPAD-1:0]             weak_pulldown_ctl;
  logic [NPAD-1:0]             dout;
  logic [NPAD-1:0]             usbPu;

  modport ctl (output cfg, funcOut, matrixOut, usbEn, dpPullup, dmPullup, strapHold,
               input ie, oe, weak_pullup_ctl, weak_pulldown_ctl, dout, usbPu);
  modport dec (input cfg, funcOut, matrixOut, usbEn, dpPullup, dmPullup, strapHold,
               output ie, oe, weak_pullup_ctl, weak_pulldown_ctl, dout, usbPu);
endinterface

`default_nettype wire

// ===== rtl/bsp_pad_decode.sv
// per-pad decode of configuration words into pad control levels
`default_nettype none

module bsp_pad_decode import bsp_pkg::*; #(
  parameter int NPAD = PAD_COUNT
) (
  // pad control carrier
  bsp_pad_if.dec pads
);

  // ----------------------------------------------------------------
  // one decoder per pad
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NPAD; i++) begin : g_pad
    localparam bit IS_USB   = (i == USB_MINUS_IDX) || (i == USB_PLUS_IDX);
    localparam bit IS_STRAP = (i == STRAP_A_IDX) || (i == STRAP_B_IDX);
    logic              usbOwn;
    logic [CFG_FUNCW-1:0] fsel;

    assign usbOwn = IS_USB && pads.usbEn;
    assign fsel   = pads.cfg[i][CFG_FUNC +: CFG_FUNCW];

    assign pads.ie[i] = pads.cfg[i][CFG_IE];
    // straps are never driven while they are still being sampled
    assign pads.oe[i] = pads.cfg[i][CFG_OE] && !(IS_STRAP && pads.strapHold);  // RULE2
    // with usb enabled, usb owns the pull-up of its data pads; their general pulls are masked
    assign pads.weak_pullup_ctl[i] = pads.cfg[i][CFG_WPU] && !usbOwn;  // RULE11 RULE12
    assign pads.weak_pulldown_ctl[i] = pads.cfg[i][CFG_WPD] && !usbOwn;  // RULE12
    assign pads.usbPu[i] = usbOwn &&
                           ((i == USB_PLUS_IDX) ? pads.dpPullup : pads.dmPullup);  // RULE11
    // routing matrix overrides the mux default function
    assign pads.dout[i] = pads.cfg[i][CFG_MTX] ? pads.matrixOut[i] :
                          (fsel < CFG_FUNCW'(FUNC_N)) ? pads.funcOut[i][fsel] :
                          1'b0;  // RULE13
  end

endmodule

`default_nettype wire

// ===== sim/bsp_board_model.sv
// board strap resistors feeding the pad input levels
`default_nettype none

module bsp_board_model import bsp_pkg::*; (
  // clock and strap choice: 0 low, 1 high, 2 floating
  input  wire logic                 sys_clk,
  input  wire logic [1:0]           strapASel,
  input  wire logic [1:0]           strapBSel,
  // pad levels
  output logic      [PAD_COUNT-1:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fltR = 1'b0;
  // an unpulled line has no defined level, so it keeps changing
  always @(posedge sys_clk) fltR <= ~fltR;
  always_comb begin
    padIn              = 19'h2a5a5;
    padIn[STRAP_A_IDX] = strapASel[1] ? fltR : strapASel[0];
    padIn[STRAP_B_IDX] = strapBSel[1] ? fltR : strapBSel[0];
  end
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench for the boot strap and pad default block
`default_nettype none

module tb_top import bsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0]     SA [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
  localparam logic [1:0]     SB [4] = '{2'h1, 2'h1, 2'h0, 2'h0};
  localparam bsp_boot_mode_t EM [4] = '{BOOT_FLASH, BOOT_FLASH, BOOT_JOINT_DL, BOOT_UNDEFINED};
  localparam logic [31:0]    CV [3] = '{32'h22, 32'h02, 32'h12};
  logic sys_clk = 0, resetn = 0, fuseDebugPadDisable = 0, bootModeValid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp, aSel = 2'h1, bSel = 2'h1;
  logic [PAD_COUNT-1:0] padIn, padInputBufferEnable, padOutputEnable, padWeakPullupCtl;
  logic [PAD_COUNT-1:0] padWeakPulldownCtl, padUsbPadPullupCtl, padOut;
  logic [USB_VAL_W-1:0] usbPullupValue;
  bsp_boot_mode_t bootMode;
  int failures = 0, check_count = 0;

  bsp_boot_strap i_dut (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .padIn, .padFuncOut({PAD_COUNT{3'h2}}), .padMatrixOut({PAD_COUNT{1'b1}}),
    .fuseDebugPadDisable, .padInputBufferEnable, .padOutputEnable, .padWeakPullupCtl,
    .padWeakPulldownCtl, .padUsbPadPullupCtl, .padOut, .usbPullupValue, .bootMode,
    .bootModeValid);
  bsp_board_model i_board (.sys_clk, .strapASel(aSel), .strapBSel(bSel), .padIn);

  initial forever #12.5 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // bounded wait: a stuck handshake ends the run
  task automatic tick(inout int n);
    @(posedge sys_clk);
    n++;
    if (n > 40) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    // one edge between transfers, so no signal is set twice in a step
    @(posedge sys_clk);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    @(posedge sys_clk);
  endtask

  // expected {wpd, wpu, oe, ie} of one pad
  function automatic logic [3:0] img(int i, logic inRst);
    case (PAD_RST_CODE[i])
      3'h0: return 4'h0;
      3'h2: return 4'h9;
      3'h3: return 4'h5;
      3'h4: return 4'h6;
      3'h5: return {1'b0, inRst | !fuseDebugPadDisable, 2'b01};
      default: return 4'h1;
    endcase
  endfunction

  task automatic chkImg(input logic inRst);
    logic [3:0] pv;
    for (int i = 0; i < PAD_COUNT; i++) begin
      pv = {padWeakPulldownCtl[i], padWeakPullupCtl[i],
            padOutputEnable[i], padInputBufferEnable[i]};
      chk(pv, img(i, inRst));
    end
    chk(padUsbPadPullupCtl, inRst ? 0 : 1 << USB_PLUS_IDX);
  endtask

  initial begin
    @(posedge sys_clk);
    for (int t = 0; t < 4; t++) begin
      aSel                <= SA[t];
      bSel                <= SB[t];
      fuseDebugPadDisable <= t[0];
      resetn              <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chkImg(1'b1);
      resetn <= 1'b1;
      repeat (5) @(posedge sys_clk);
      chkImg(1'b0);
      chk(usbPullupValue, 0);
      chk(bootModeValid, 1'b1);
      chk(bootMode, EM[t]);
      axw(ADDR_BOOT_STATUS, 32'hffffffff, RESP_OKAY);
      if (t > 0) begin
        axr(ADDR_BOOT_STATUS, {t[0], 1'b1, SB[t][0], SA[t][0], EM[t]}, RESP_OKAY);
      end
      axw(ADDR_USB_CTRL, 32'h28, RESP_OKAY);
      axr(ADDR_USB_CTRL, 32'h28, RESP_OKAY);
      chk({padWeakPullupCtl[18:17], padWeakPulldownCtl[18:17]}, 0);
      chk(padUsbPadPullupCtl, 0);
      chk(usbPullupValue, 3'h5);
      axw(ADDR_PAD_CFG_BASE + 8'd68, 32'h5, RESP_OKAY);
      axr(ADDR_PAD_CFG_BASE + 8'd68, 32'h5, RESP_OKAY);
      chk(padWeakPullupCtl[USB_MINUS_IDX], 1'b1);
      for (int k = 0; k < 3; k++) begin
        axw(ADDR_PAD_CFG_BASE + 8'd24, CV[k], RESP_OKAY);
        @(posedge sys_clk);
        chk({padOutputEnable[STRAP_A_IDX], padOut[STRAP_A_IDX]}, {1'b1, k != 1});
      end
      axw(8'h20, 32'h1, RESP_SLVERR);
      axr(8'h20, 32'h0, RESP_SLVERR);
      $display("case %0d done", t);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
